// ===== src/dwt_params.svh
// Purpose: constants for the dual watchdog timer
// Assumes: 100 MHz clock, one-second tick derived by a divider
// Notes:   action and interval codes are the select inputs' encodings
`ifndef DWT_PARAMS_SVH
`define DWT_PARAMS_SVH

`define DWT_CLK_HZ         100000000
`define DWT_SEC_CYCLES     (`DWT_CLK_HZ * 1)
`define DWT_CNT_W          10
`define DWT_ACT_W          4
`define DWT_IVL_W          4
`define DWT_IRQ_W          16
`define DWT_ACT_RESET      4'hC
`define DWT_ACT_NMI        4'hB
`define DWT_IVL_DEFAULT    4'h6
`define DWT_IVL_MAX        4'h9

`endif

// ===== src/dwt_pkg.sv
// Purpose: types for the dual watchdog timer
// Assumes: constants come from dwt_params.svh
// Notes:   one state struct per timer instance
`include "dwt_params.svh"
package dwt_pkg;
    typedef enum logic [1:0] {
        DWT_IDLE,
        DWT_RUN,
        DWT_FIRED
    } dwt_state_t;

    typedef struct packed {
        dwt_state_t           st;
        logic [`DWT_CNT_W:0]  cnt;
        logic                 rst_out;
        logic                 nmi_out;
        logic [`DWT_IRQ_W-1:0] irq_out;
    } dwt_regs_t;

    // shared seconds divider state
    typedef struct packed {
        logic [31:0]          div;
    } dwt_base_t;
endpackage

// ===== src/dwt_top.sv
// Purpose: two independent watchdog timers with selectable expiry action
// Assumes: restart inputs are one-cycle pulses from on-clock logic
// Notes:   the seconds tick is shared; a restart may land mid-second
//
// Function
// - each timer has its own enable; disabled means no count, no action
// - action selects irq 3..15 subset, nmi or reset; reset by default
// - interval is 1 to 512 seconds in powers of two; 64 by default
// - enabled timer counts down from interval and fires action at zero
// - a restart before zero reloads the full selected interval
`timescale 1ns/10ps
`include "dwt_params.svh"

module dwt_timer
    import dwt_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // time base and control
    input  wire logic                  sec_tick,
    input  wire logic                  enable,
    input  wire logic                  restart,
    input  wire logic [`DWT_ACT_W-1:0] act_sel,
    input  wire logic [`DWT_IVL_W-1:0] ivl_sel,
    // expiry outputs
    output logic                       sys_reset,
    output logic                       nmi,
    output logic [`DWT_IRQ_W-1:0]      irq
);
    dwt_regs_t s_r;
    dwt_regs_t s_nxt;
    logic [`DWT_CNT_W:0] load_val;
    logic [`DWT_IRQ_W-1:0] irq_vec;
    logic expire;

    ////////////////////////////////////////////////////////////////////////
    // interval decode; out-of-range codes fall back to the default
    always_comb begin
        if (ivl_sel <= `DWT_IVL_MAX) begin
            load_val = (`DWT_CNT_W+1)'(1) << ivl_sel;
        end else begin
            load_val = (`DWT_CNT_W+1)'(1) << `DWT_IVL_DEFAULT;
        end
    end

    // action decode: codes 0..A map to irq 3,4,5,6,7,9,10,11,12,14,15
    always_comb begin
        irq_vec = '0;
        case (act_sel)
            4'h0: irq_vec[3] = 1'b1;
            4'h1: irq_vec[4] = 1'b1;
            4'h2: irq_vec[5] = 1'b1;
            4'h3: irq_vec[6] = 1'b1;
            4'h4: irq_vec[7] = 1'b1;
            4'h5: irq_vec[9] = 1'b1;
            4'h6: irq_vec[10] = 1'b1;
            4'h7: irq_vec[11] = 1'b1;
            4'h8: irq_vec[12] = 1'b1;
            4'h9: irq_vec[14] = 1'b1;
            4'hA: irq_vec[15] = 1'b1;
            default: irq_vec = '0;
        endcase
    end

    assign expire = (s_r.st == DWT_RUN) && sec_tick && !restart
                    && (s_r.cnt == (`DWT_CNT_W+1)'(1));

    ////////////////////////////////////////////////////////////////////////
    // next state; reset action latches until restart or disable since it resets
    // the system anyway, interrupt actions pulse and reload
    always_comb begin
        s_nxt = s_r;
        s_nxt.nmi_out = 1'b0;
        s_nxt.irq_out = '0;
        case (s_r.st)
            DWT_IDLE: begin
                if (enable) begin
                    s_nxt.st = DWT_RUN;
                    s_nxt.cnt = load_val;
                end
            end
            DWT_RUN: begin
                if (restart) begin
                    s_nxt.cnt = load_val;
                end else if (expire) begin
                    if (act_sel == `DWT_ACT_NMI) begin
                        s_nxt.nmi_out = 1'b1;
                        s_nxt.cnt = load_val;
                    end else if (irq_vec != '0) begin
                        s_nxt.irq_out = irq_vec;
                        s_nxt.cnt = load_val;
                    end else begin
                        s_nxt.rst_out = 1'b1;
                        s_nxt.cnt = '0;
                        s_nxt.st = DWT_FIRED;
                    end
                end else if (sec_tick) begin
                    s_nxt.cnt = s_r.cnt - (`DWT_CNT_W+1)'(1);
                end
            end
            DWT_FIRED: begin
                if (restart) begin
                    s_nxt.rst_out = 1'b0;
                    s_nxt.st = DWT_RUN;
                    s_nxt.cnt = load_val;
                end
            end
            default: s_nxt.st = DWT_IDLE;
        endcase
        if (!enable) begin
            s_nxt.st = DWT_IDLE;
            s_nxt.cnt = '0;
            s_nxt.rst_out = 1'b0;
            s_nxt.nmi_out = 1'b0;
            s_nxt.irq_out = '0;
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '{st: DWT_IDLE, cnt: '0, rst_out: 1'b0,
                     nmi_out: 1'b0, irq_out: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sys_reset = s_r.rst_out;
    assign nmi = s_r.nmi_out;
    assign irq = s_r.irq_out;

    ////////////////////////////////////////////////////////////////////////
    // checks; one clock domain, so clock and reset are given once here
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // last second of a countdown that nothing interrupts
    sequence seq_last_sec;
        s_r.st == DWT_RUN && s_r.cnt == 1 && sec_tick && !restart && enable;
    endsequence

    a_disable_quiet: assert property (
        !enable |=> !sys_reset && !nmi && irq == '0 && s_r.cnt == 0)
        else $error("disabled timer shows activity");
    a_zero_fires: assert property (
        seq_last_sec |=> (sys_reset || nmi || irq != '0))
        else $error("expiry did not fire an action");
    a_nmi_select: assert property (
        seq_last_sec ##0 (act_sel == `DWT_ACT_NMI) |=> nmi && !sys_reset)
        else $error("nmi not raised on nmi select");
    a_reset_select: assert property (
        seq_last_sec ##0 (act_sel == `DWT_ACT_RESET) |=> sys_reset)
        else $error("reset not raised on reset select");
    a_reset_hold: assert property (
        sys_reset && enable && !restart |=> sys_reset)
        else $error("reset action dropped without restart");
    a_restart_reload: assert property (
        restart && enable && s_r.st == DWT_RUN |=>
        s_r.cnt == $past(load_val))
        else $error("restart did not reload interval");
    a_irq_reload: assert property (
        seq_last_sec ##0 (act_sel <= 4'hA) |=>
        s_r.cnt == $past(load_val) && s_r.st == DWT_RUN)
        else $error("irq expiry did not reload");
    a_count_step: assert property (
        s_r.st == DWT_RUN && sec_tick && !restart && enable
        && s_r.cnt > 1 |=> s_r.cnt == $past(s_r.cnt) - 1)
        else $error("count did not step down");
    a_enable_load: assert property (
        s_r.st == DWT_IDLE && enable && ivl_sel == 4'h6 |=>
        s_r.cnt == 64)
        else $error("interval 64 not loaded");
endmodule

module dwt_top
    import dwt_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // first_watchdog control
    input  wire logic                  first_watchdog_enable,
    input  wire logic                  first_watchdog_restart,
    input  wire logic [`DWT_ACT_W-1:0] first_watchdog_act,
    input  wire logic [`DWT_IVL_W-1:0] first_watchdog_ivl,
    // second_watchdog control
    input  wire logic                  second_watchdog_enable,
    input  wire logic                  second_watchdog_restart,
    input  wire logic [`DWT_ACT_W-1:0] second_watchdog_act,
    input  wire logic [`DWT_IVL_W-1:0] second_watchdog_ivl,
    // expiry outputs
    output logic                       first_watchdog_reset,
    output logic                       first_watchdog_nmi,
    output logic [`DWT_IRQ_W-1:0]      first_watchdog_irq,
    output logic                       second_watchdog_reset,
    output logic                       second_watchdog_nmi,
    output logic [`DWT_IRQ_W-1:0]      second_watchdog_irq
);
    parameter int SEC_CYCLES = `DWT_SEC_CYCLES;
    dwt_base_t   b_r;
    dwt_base_t   b_nxt;
    logic        tick;

    ////////////////////////////////////////////////////////////////////////
    // shared one-second enable; free running so restarts land mid-second
    // and the first second after restart may be short by up to SEC_CYCLES - 1 clocks
    assign tick = (b_r.div == 32'(SEC_CYCLES - 1));

    // next divider value; wraps on the tick cycle
    always_comb begin
        b_nxt = b_r;
        if (tick) begin
            b_nxt.div = 32'h0;
        end else begin
            b_nxt.div = b_r.div + 32'h1;
        end
    end

    // divider register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            b_r <= '0;
        end else begin
            b_r <= b_nxt;
        end
    end

    // two identical timers
    dwt_timer u_first (
        .clock     (clock),
        .rst       (rst),
        .sec_tick  (tick),
        .enable    (first_watchdog_enable),
        .restart   (first_watchdog_restart),
        .act_sel   (first_watchdog_act),
        .ivl_sel   (first_watchdog_ivl),
        .sys_reset (first_watchdog_reset),
        .nmi       (first_watchdog_nmi),
        .irq       (first_watchdog_irq)
    );
    dwt_timer u_second (
        .clock     (clock),
        .rst       (rst),
        .sec_tick  (tick),
        .enable    (second_watchdog_enable),
        .restart   (second_watchdog_restart),
        .act_sel   (second_watchdog_act),
        .ivl_sel   (second_watchdog_ivl),
        .sys_reset (second_watchdog_reset),
        .nmi       (second_watchdog_nmi),
        .irq       (second_watchdog_irq)
    );
endmodule

// ===== test/dwt_sink.sv
// Purpose: interrupt controller and reset sink model
// Assumes: nmi and irq are one-cycle pulses
// Notes:   counts events so the bench can judge rates
`timescale 1ns/10ps
`include "dwt_params.svh"
module dwt_sink (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // expiry lines
    input  wire logic                  sys_reset,
    input  wire logic [`DWT_IRQ_W-1:0] irq,
    input  wire logic                  nmi,
    // event counts
    output int                         n_nmi,
    output int                         n_irq,
    output int                         n_rst
);
    logic rst_q;

    // pulses count once per high cycle; reset is a level, so only its
    // rising edge counts, else a latched reset would count every cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            n_nmi <= 0;
            n_irq <= 0;
            n_rst <= 0;
            rst_q <= 1'b0;
        end else begin
            rst_q <= sys_reset;
            if (nmi) n_nmi <= n_nmi + 1;
            if (irq != 16'h0000) n_irq <= n_irq + 1;
            if (sys_reset && !rst_q) n_rst <= n_rst + 1;
        end
    end
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the dual watchdog timer
// Assumes: SEC_CYCLES of 4 so one second is four clocks
// Notes:   the first second after load may be short, so waits are ranges
`timescale 1ns/10ps
`include "dwt_params.svh"
module tb;
    logic clock = 0, rst = 1, e1 = 0, r1 = 0, e2 = 0, r2 = 0;
    logic [3:0] a1 = 4'hC, v1 = 4'h6, a2 = 4'hC, v2 = 4'h6;
    logic o1, n1, o2, n2;
    logic [15:0] q1, q2;
    int n_mismatch = 0, n_checks = 0, c1, c2, k;
    int tbl[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    dwt_top #(.SEC_CYCLES(4)) dut_u (.clock(clock), .rst(rst),
        .first_watchdog_enable(e1), .first_watchdog_restart(r1),
        .first_watchdog_act(a1), .first_watchdog_ivl(v1),
        .second_watchdog_enable(e2), .second_watchdog_restart(r2),
        .second_watchdog_act(a2), .second_watchdog_ivl(v2),
        .first_watchdog_reset(o1), .first_watchdog_nmi(n1),
        .first_watchdog_irq(q1), .second_watchdog_reset(o2),
        .second_watchdog_nmi(n2), .second_watchdog_irq(q2));
    dwt_sink s1 (.clock(clock), .rst(rst), .sys_reset(o1), .irq(q1),
        .nmi(n1), .n_nmi(), .n_irq(), .n_rst());
    dwt_sink s2 (.clock(clock), .rst(rst), .sys_reset(o2), .irq(q2),
        .nmi(n2), .n_nmi(), .n_irq(), .n_rst());
    ////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(negedge clock);
    endtask
    // load the first timer; disable first so each case starts from idle
    task automatic arm(input logic [3:0] act, input logic [3:0] ivl);
        e1 = 0;
        go(2);
        a1 = act;
        v1 = ivl;
        e1 = 1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // one timer disabled stays silent while the other repeats nmi
    task automatic t_indep;
        a2 = 4'hB;
        v2 = 4'h0;
        e2 = 1;
        go(12);
        c1 = s1.n_nmi + s1.n_irq;
        c2 = s2.n_nmi;
        go(40);
        check(s1.n_nmi + s1.n_irq + o1, c1);
        check(s2.n_nmi - c2, 10);
        e2 = 0;
    endtask
    // every irq code raises its own one-hot line, then nmi repeats
    task automatic t_irq;
        for (int i = 0; i < 11; i++) begin
            arm(i[3:0], 4'h0);
            k = 0;
            while (q1 == 16'h0000 && k < 12) begin
                go(1);
                k++;
            end
            check(q1, 32'h1 << tbl[i]);
        end
        arm(4'hB, 4'h0);
        go(10);
        c1 = s1.n_nmi;
        go(40);
        check(s1.n_nmi - c1, 10);
    endtask
    // reset action timing per interval; codes D and F fall back
    task automatic t_ivl;
        logic [3:0] acts[4] = '{4'hC, 4'hC, 4'hC, 4'hD};
        logic [3:0] ivls[4] = '{4'h0, 4'h3, 4'h9, 4'hF};
        int exps[4] = '{0, 3, 9, 6};
        for (int i = 0; i < 4; i++) begin
            arm(acts[i], ivls[i]);
            k = 0;
            while (o1 !== 1'b1 && k < 2100) begin
                go(1);
                k++;
            end
            check(k >= ((1 << exps[i]) - 1) * 4, 1);
            check(k <= (1 << exps[i]) * 4 + 3, 1);
            go(20);
            check(o1, 1);
        end
        r1 = 1;
        go(1);
        r1 = 0;
        go(2);
        check(o1, 0);
    endtask
    // restarts every 4 cycles hold off a 2 second expiry
    task automatic t_restart;
        arm(4'hB, 4'h1);
        c1 = s1.n_nmi;
        repeat (15) begin
            go(3);
            r1 = 1;
            go(1);
            r1 = 0;
        end
        check(s1.n_nmi - c1, 0);
        go(12);
        check(s1.n_nmi - c1 > 0, 1);
        e1 = 0;
    endtask
    // second timer: load 64, restart to 1 s, reset action, mid-run reset
    task automatic t_rst;
        c2 = s2.n_rst;
        a2 = 4'hC;
        v2 = 4'h6;
        e2 = 1;
        go(1);
        v2 = 4'h0;
        r2 = 1;
        go(1);
        r2 = 0;
        go(6);
        check(o2, 1);
        check(s2.n_rst - c2, 1);
        check({n2, q2}, 0);
        rst = 1;
        go(1);
        check(o2, 0);
        rst = 0;
        go(1);
        check({o2, n2, q2}, 0);
        go(6);
        check(o2, 1);
        e2 = 0;
        go(2);
        check(o2, 0);
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        go(8);
        rst = 0;
        go(1);
        check({o1, n1, q1, o2, n2, q2}, 0);
        t_indep();
        t_irq();
        t_ivl();
        t_restart();
        t_rst();
        test_done();
    end
    // watchdog cuts a hang well past the expected run
    initial begin
        #60000;
        n_mismatch++;
        test_done();
    end
endmodule
